// file: pdamw_checker.sv
// concurrent checks on the mode register write qualifier ports
`timescale 1ns/100ps
`default_nettype none
module pdamw_checker (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        mrs_cmd,
  input wire logic        pda_active,
  input wire logic        mrs_exec,
  input wire logic        mrs_discard,
  input wire logic        term_dynamic_allowed,
  input wire logic        vref_settled
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_plain_cmd;
    mrs_cmd && !pda_active;
  endsequence
  sequence s_qual_cmd;
    mrs_cmd && pda_active;
  endsequence
  a_ack_answer: assert property (s_bus_req |=> wb_ack_o)
    else $error("bus request not acked");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_hole_zero: assert property (s_bus_req ##0 (!wb_we_i && wb_adr_i == 8'h14)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_plain_exec: assert property (s_plain_cmd |=> mrs_exec && !mrs_discard)
    else $error("plain command not executed");
  a_result_excl: assert property (!(mrs_exec && mrs_discard))
    else $error("exec and discard together");
  a_discard_mode: assert property (mrs_discard |-> pda_active)
    else $error("discard outside qualified mode");
  // the strobe passes two sync flops, so no answer can come at once
  a_qual_wait: assert property (s_qual_cmd |=> !mrs_exec && !mrs_discard)
    else $error("qualified command answered before strobe");
  a_dyn_term_off: assert property (pda_active |-> !term_dynamic_allowed)
    else $error("dynamic termination allowed in qualified mode");
  a_mode_moves: assert property ($changed(pda_active) |-> mrs_exec || $past(mrs_exec))
    else $error("mode changed without executed write");
  a_settle_hold: assert property ($fell(vref_settled) |-> !vref_settled [*8])
    else $error("settle window too short");
endmodule // pdamw_checker
bind pdamw_top pdamw_checker chk_i (.mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .mrs_cmd, .pda_active, .mrs_exec, .mrs_discard,
  .term_dynamic_allowed, .vref_settled);
`default_nettype wire

// file: pdamw_consts.vh
// constants for the per-device mode register write block
// Contract
// (R1) Mode register 3 bit 4 written one enters per-device mode; resets to zero.
// (R2) In per-device mode, execute a mode register write when captured DQ0 is zero.
// (R3) In per-device mode, drop the write, registers unchanged, when DQ0 is one.
// (R4) DQ0 is captured with the data strobe like an ordinary write burst.
// (R5) Controller issues only mode register writes while per-device mode is on.
// (R6) Controller spaces mode writes by AL+WL+BL/2-0.5 clock+write gap+parity latency.
// (R7) Writing MR3 bit 4 zero with DQ0 low leaves per-device mode.
// (R8) Controller finishes write leveling before enabling per-device mode.
// (R9) No dynamic termination switching during the qualifying transfer in per-device mode.
// (R10) With MR1[10:8] nonzero, lane termination follows ODT pin with direct/async delays.
// (R11) Controller sets reference level to midpoint or trained centre before entry.
// (R12) Controller holds DQ0 stable over the whole four- or eight-beat transfer.
// (R13) Sample DQ0 on first falling or second rising strobe edge.
// (R14) Controller may drive the qualifying level on every data bit.
// (R15) Exit rewrites all of MR3, so controller supplies a complete value.
// (R16) MR6 bit 6 picks range: 60-92 percent or 45-77 percent of supply.
// (R17) Reference level is base plus code times a fixed 0.65 percent step.
// (R18) Controller waits up to 150 ns after a reference change before relying on it.
// (R19) With monitor on, controller adds 10 ns plus 15 ns per picofarad.
// (R20) Controller should calibrate the reference level for best receiver margin.
// (R21) Reference setting is the last MR6[6:0] written before calibration mode exits.
// (R22) Outside per-device mode every mode register write executes regardless of DQ0.
`ifndef PDAMW_CONSTS_VH
`define PDAMW_CONSTS_VH
`define PDAMW_CLK_MHZ       100
`define PDAMW_ADR_CTRL      8'h00
`define PDAMW_ADR_STATUS    8'h04
`define PDAMW_ADR_MRSEL     8'h08
`define PDAMW_ADR_MRDATA    8'h0c
`define PDAMW_ADR_VREF      8'h10
`define PDAMW_CTRL_FALL     0
`define PDAMW_CTRL_ASYNC    1
`define PDAMW_MR1           3'h1
`define PDAMW_MR3           3'h3
`define PDAMW_MR5           3'h5
`define PDAMW_MR6           3'h6
`define PDAMW_MR3_PDA       4
`define PDAMW_MR6_CAL       7
`define PDAMW_MR6_RANGE     6
`define PDAMW_VREF_RST      7'h00
`define PDAMW_R1_BASE       14'h1770
`define PDAMW_R2_BASE       14'h1194
`define PDAMW_STEP          14'h0041
`define PDAMW_VREF_TIME_NS  150
`define PDAMW_VREF_CYC      ((`PDAMW_VREF_TIME_NS * `PDAMW_CLK_MHZ) / 1000)
`define PDAMW_WAIT_CYC      8'h40
`define PDAMW_DON_LAT       9
`define PDAMW_DOFF_LAT      9
`define PDAMW_AON_NS        9
`define PDAMW_AOFF_NS       9
`define PDAMW_AON_CYC       ((`PDAMW_AON_NS * `PDAMW_CLK_MHZ) / 1000)
`define PDAMW_AOFF_CYC      ((`PDAMW_AOFF_NS * `PDAMW_CLK_MHZ) / 1000)
`define PDAMW_TERM_DEPTH    16
`endif

// file: pdamw_ctl_model.sv
// memory controller model driving commands, strobe, lane 0 and odt
`timescale 1ns/100ps
`default_nettype none
module pdamw_ctl_model #(parameter int GAP = 20) (
  input  wire logic        mclk,
  output var  logic        mrs_cmd,
  output var  logic [2:0]  mrs_reg,
  output var  logic [13:0] mrs_addr,
  output var  logic        dqs_pin,
  output var  logic        dq0_pin,
  output var  logic        odt_pin
);
  // write leveling and a centred reference are assumed done before entry
  initial begin
    mrs_cmd = 1'b0;
    mrs_reg = 3'h0;
    mrs_addr = 14'h0;
    dqs_pin = 1'b0;
    dq0_pin = 1'b1;
    odt_pin = 1'b0;
  end
  // only mode writes are ever issued; exit carries a whole register value
  task automatic send(input logic [2:0] r, input logic [13:0] a, input logic q,
                      input logic qual);
    @(posedge mclk);
    mrs_cmd <= 1'b1;
    mrs_reg <= r;
    mrs_addr <= a;
    dq0_pin <= q; // lane 0 only; the rest of the group is not modelled
    @(posedge mclk);
    mrs_cmd <= 1'b0;
    mrs_reg <= ~r;
    mrs_addr <= ~a;
    // lane held for all four strobe periods, strobe idle low outside
    if (qual) begin
      repeat (4) begin
        repeat (8) @(posedge mclk);
        dqs_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        dqs_pin <= 1'b0;
      end
    end
    @(posedge mclk);
    dq0_pin <= ~q;
    // the gap also covers the 150 ns reference settle; the monitor stays off
    repeat (GAP) @(posedge mclk);
  endtask
  task automatic odt(input logic v);
    @(posedge mclk);
    odt_pin <= v;
  endtask
endmodule // pdamw_ctl_model
`default_nettype wire

// file: pdamw_term_delay.v
// termination delay line following the synchronised odt level
`timescale 1ns/100ps
`default_nettype none
`include "pdamw_consts.vh"
module pdamw_term_delay (
  input  wire mclk,
  input  wire resetn,
  input  wire odt_level,
  input  wire async_mode,
  output reg  term_on
);
  reg  [`PDAMW_TERM_DEPTH-1:0] line;
  wire                         on_tap;
  wire                         off_tap;

  // async delays are short, so they tap the line near its head
  assign on_tap  = async_mode ? line[`PDAMW_AON_CYC]  : line[`PDAMW_DON_LAT - 1];  // [R10]
  assign off_tap = async_mode ? line[`PDAMW_AOFF_CYC] : line[`PDAMW_DOFF_LAT - 1]; // [R10]

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      line    <= {`PDAMW_TERM_DEPTH{1'b0}};
      term_on <= 1'b0;
    end else begin
      line <= {line[`PDAMW_TERM_DEPTH-2:0], odt_level};
      if (on_tap)
        term_on <= 1'b1;
      else if (!off_tap)
        term_on <= 1'b0;
    end
  end
endmodule // pdamw_term_delay
`default_nettype wire

// file: pdamw_test.sv
// testbench: register bus and mode write sequences with expected values
`timescale 1ns/100ps
`default_nettype none
`include "pdamw_consts.vh"
module pdamw_test;
  logic mclk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, rd;
  wire logic [31:0] wb_dat_o;
  wire logic [13:0] mrs_addr, vref_level;
  wire logic [5:0]  vref_code;
  wire logic [2:0]  mrs_reg;
  wire logic wb_ack_o, mrs_cmd, dqs_pin, dq0_pin, odt_pin, pda_active, mrs_exec;
  wire logic mrs_discard, term_nominal_on, term_park_on, term_dynamic_allowed;
  wire logic vref_range, vref_settled;
  int fails = 0, samples_checked = 0, n_exec = 0, n_disc = 0, n0 = 0;
  pdamw_top dut (.mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .mrs_cmd, .mrs_reg, .mrs_addr, .dqs_pin, .dq0_pin,
    .odt_pin, .pda_active, .mrs_exec, .mrs_discard, .term_nominal_on, .term_park_on,
    .term_dynamic_allowed, .vref_range, .vref_code, .vref_level, .vref_settled);
  pdamw_ctl_model ctl (.mclk, .mrs_cmd, .mrs_reg, .mrs_addr, .dqs_pin, .dq0_pin, .odt_pin);
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (mrs_exec === 1'b1) n_exec++;
    if (mrs_discard === 1'b1) n_disc++;
  end
  task chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // the slave's latency is not assumed; the ack wait is bounded only
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    chk("ack", wb_ack_o, 1'b1);
  endtask
  task mrs(input logic [2:0] r, input logic [13:0] a, input logic q, input int ex, dc);
    int e0, d0;
    e0 = n_exec;
    d0 = n_disc;
    ctl.send(r, a, q, pda_active);
    chk("exec", n_exec - e0, ex);
    chk("discard", n_disc - d0, dc);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("level", vref_level, 14'h1770);
    chk("dyn", term_dynamic_allowed, 1'b1);
    wb(0, `PDAMW_ADR_STATUS, 0);
    chk("status", rd[0], 1'b0);
    wb(0, 8'h14, 0);
    chk("hole", rd, 32'h0);
    $display("test reset done");
    mrs(`PDAMW_MR5, 14'h0040, 1, 1, 0);
    chk("park", term_park_on, 1'b1);
    mrs(`PDAMW_MR3, 14'h0010, 0, 1, 0);
    chk("mode", pda_active, 1'b1);
    chk("dyn", term_dynamic_allowed, 1'b0);
    mrs(`PDAMW_MR1, 14'h0100, 1, 0, 1);
    wb(1, `PDAMW_ADR_MRSEL, 32'h1);
    wb(0, `PDAMW_ADR_MRDATA, 0);
    chk("mr1", rd, 32'h0);
    mrs(`PDAMW_MR1, 14'h0100, 0, 1, 0);
    wb(0, `PDAMW_ADR_MRDATA, 0);
    chk("mr1", rd, 32'h100);
    wb(1, `PDAMW_ADR_CTRL, 32'h1);
    mrs(`PDAMW_MR1, 14'h0200, 0, 1, 0);
    wb(0, `PDAMW_ADR_MRDATA, 0);
    chk("mr1", rd, 32'h200);
    wb(1, `PDAMW_ADR_CTRL, 32'h0);
    n0 = n_exec + n_disc;
    ctl.send(`PDAMW_MR1, 14'h0300, 1'b0, 1'b0);
    repeat (60) @(posedge mclk);
    chk("cut", n_exec + n_disc - n0, 0);
    wb(0, `PDAMW_ADR_MRDATA, 0);
    chk("mr1", rd, 32'h200);
    wb(0, `PDAMW_ADR_STATUS, 0);
    chk("idle", rd[1], 1'b0);
    mrs(`PDAMW_MR3, 14'h0000, 1, 0, 1);
    chk("mode", pda_active, 1'b1);
    mrs(`PDAMW_MR3, 14'h0000, 0, 1, 0);
    chk("mode", pda_active, 1'b0);
    $display("test qualify done");
    ctl.odt(1);
    repeat (6) @(posedge mclk);
    chk("nominal", term_nominal_on, 1'b0);
    repeat (14) @(posedge mclk);
    chk("nominal", term_nominal_on, 1'b1);
    chk("park", term_park_on, 1'b0);
    ctl.odt(0);
    repeat (20) @(posedge mclk);
    chk("nominal", term_nominal_on, 1'b0);
    wb(1, `PDAMW_ADR_CTRL, 32'h2);
    ctl.odt(1);
    repeat (6) @(posedge mclk);
    chk("nominal", term_nominal_on, 1'b1);
    ctl.odt(0);
    repeat (6) @(posedge mclk);
    chk("nominal", term_nominal_on, 1'b0);
    wb(1, `PDAMW_ADR_CTRL, 32'h0);
    $display("test termination done");
    mrs(`PDAMW_MR6, 14'h00c0, 1, 1, 0);
    mrs(`PDAMW_MR6, 14'h00c5, 1, 1, 0);
    chk("code", vref_code, 6'h00);
    mrs(`PDAMW_MR6, 14'h0000, 1, 1, 0);
    chk("range", vref_range, 1'b1);
    chk("code", vref_code, 6'h05);
    chk("level", vref_level, 14'h12d9);
    chk("settled", vref_settled, 1'b1);
    $display("test reference done");
    close_out;
  end
  initial begin
    #100us;
    fails++;
    $display("BAD watchdog expected done seen hang");
    close_out;
  end
endmodule // pdamw_test
`default_nettype wire

// file: pdamw_top.v
// per-device mode register write qualifier with reference level selection
`timescale 1ns/100ps
`default_nettype none
`include "pdamw_consts.vh"
module pdamw_top (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        mrs_cmd,
  input  wire [2:0]  mrs_reg,
  input  wire [13:0] mrs_addr,
  input  wire        dqs_pin,
  input  wire        dq0_pin,
  input  wire        odt_pin,
  output reg         pda_active,
  output reg         mrs_exec,
  output reg         mrs_discard,
  output wire        term_nominal_on,
  output wire        term_park_on,
  output wire        term_dynamic_allowed,
  output reg         vref_range,
  output reg  [5:0]  vref_code,
  output reg  [13:0] vref_level,
  output wire        vref_settled
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg  [2:0]  sync1;
  reg  [2:0]  sync2;
  reg         dqs_prev;
  wire        dqs_s;
  wire        dq0_s;
  wire        odt_s;
  wire        dqs_rise;
  wire        dqs_fall;

  reg         state;
  reg         next_state;
  reg  [1:0]  rise_cnt;
  reg  [2:0]  pend_reg;
  reg  [13:0] pend_addr;
  reg         last_dq0;
  reg         take;
  reg         do_write;
  reg  [2:0]  wr_reg;
  reg  [13:0] wr_addr;

  // a burst cut short would hold the wait forever, so it is bounded
  reg  [7:0]  wait_cnt;
  wire        wait_over;
  wire        qual_start;
  wire        plain_start;
  wire        drop_now;
  wire [31:0] settle_full;

  reg  [13:0] mr [0:7];
  reg  [6:0]  cal_last;
  reg  [1:0]  ctrl;
  reg  [2:0]  mr_sel;
  reg  [7:0]  exec_cnt;
  reg  [7:0]  disc_cnt;
  reg  [4:0]  settle_cnt;
  wire        term_raw;
  wire        nominal_en;
  wire        bus_req;
  integer     i;

  // level from range and code; used for the live setting only, reset loads zero
  function [13:0] level_of;
    input       range;
    input [5:0] code;
    begin
      level_of = (range ? `PDAMW_R2_BASE : `PDAMW_R1_BASE)
               + code * `PDAMW_STEP;                                         // [R16] [R17]
    end
  endfunction

  // one decode for the idle command test, plain or qualified
  function cmd_starts;
    input st;
    input cmd;
    input per_device_addressing_mode;
    input qual;
    begin
      cmd_starts = (st == ST_IDLE) && cmd && (per_device_addressing_mode == qual);
    end
  endfunction

  // pins come from outside the clock, two flops before any use
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      wire pin_in;
      assign pin_in = (g == 0) ? dqs_pin : ((g == 1) ? dq0_pin : odt_pin);
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_in;
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  assign dqs_s    = sync2[0];
  assign dq0_s    = sync2[1];
  assign odt_s    = sync2[2];
  assign dqs_rise = dqs_s & ~dqs_prev;
  assign dqs_fall = ~dqs_s & dqs_prev;

  // decoded once here, read by the machine and the write path
  assign qual_start  = cmd_starts(state, mrs_cmd, pda_active, 1'b1);
  assign plain_start = cmd_starts(state, mrs_cmd, pda_active, 1'b0);
  assign drop_now    = take & dq0_s;                                         // [R3]
  assign wait_over   = (state == ST_WAIT) && (wait_cnt == `PDAMW_WAIT_CYC);   // [R12]
  assign settle_full = `PDAMW_VREF_CYC;

  // pick the strobe edge that both burst lengths share
  always @* begin
    take = 1'b0;
    if (state == ST_WAIT && rise_cnt == 2'd1) begin
      if (ctrl[`PDAMW_CTRL_FALL])
        take = dqs_fall;                                                     // [R13]
      else
        take = dqs_rise;                                                     // [R13]
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (qual_start)
          next_state = ST_WAIT;
      end
      ST_WAIT: begin
        // a strobe that never comes gives up after the bound; command lost
        if (take || wait_over)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // decide whether a command reaches the mode registers
  always @* begin
    do_write = 1'b0;
    wr_reg   = mrs_reg;
    wr_addr  = mrs_addr;
    // plain commands bypass the strobe entirely
    if (plain_start) begin
      do_write = 1'b1;                                                       // [R22]
    end else if (take && !dq0_s) begin
      do_write = 1'b1;                                                       // [R2]
      wr_reg   = pend_reg;
      wr_addr  = pend_addr;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state       <= ST_IDLE;
      dqs_prev    <= 1'b0;
      rise_cnt    <= 2'd0;
      pend_reg    <= 3'h0;
      pend_addr   <= 14'h0000;
      last_dq0    <= 1'b0;
      mrs_exec    <= 1'b0;
      mrs_discard <= 1'b0;
      exec_cnt    <= 8'h00;
      disc_cnt    <= 8'h00;
      wait_cnt    <= 8'h00;
    end else begin
      state       <= next_state;
      dqs_prev    <= dqs_s;
      mrs_exec    <= do_write;
      mrs_discard <= drop_now;                                               // [R3]
      if (qual_start) begin
        // later commands in the wait are dropped; the controller spaces them
        pend_reg  <= mrs_reg;                                                // [R6]
        pend_addr <= mrs_addr;
        rise_cnt  <= 2'd0;
      end else if (state == ST_WAIT && dqs_rise && rise_cnt != 2'd3) begin
        // saturate so a long burst cannot wrap into a second take
        rise_cnt <= rise_cnt + 2'd1;                                         // [R4]
      end
      if (take)
        last_dq0 <= dq0_s;                                                   // [R4]
      if (do_write)
        exec_cnt <= exec_cnt + 8'h01;
      if (drop_now)
        disc_cnt <= disc_cnt + 8'h01;
      if (qual_start)
        wait_cnt <= 8'h00;
      else if (state == ST_WAIT)
        wait_cnt <= wait_cnt + 8'h01;                                        // [R12]
    end
  end

  // mode registers; a discarded command never gets here
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 8; i = i + 1)
        mr[i] <= 14'h0000;                                                   // [R1]
      pda_active <= 1'b0;
      cal_last   <= `PDAMW_VREF_RST;
      vref_range <= 1'b0;
      vref_code  <= 6'h00;
    end else if (do_write) begin
      mr[wr_reg] <= wr_addr;                                                 // [R3]
      if (wr_reg == `PDAMW_MR3)
        pda_active <= wr_addr[`PDAMW_MR3_PDA];                               // [R1] [R7]
      if (wr_reg == `PDAMW_MR6) begin
        if (wr_addr[`PDAMW_MR6_CAL]) begin
          cal_last <= wr_addr[6:0];
        end else if (mr[`PDAMW_MR6][`PDAMW_MR6_CAL]) begin
          vref_range <= cal_last[`PDAMW_MR6_RANGE];                          // [R21]
          vref_code  <= cal_last[5:0];                                       // [R21]
        end
      end
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn)
      vref_level <= 14'h0000;
    else
      vref_level <= level_of(vref_range, vref_code);                         // [R16] [R17]
  end

  // settle window after a reference write, for software to observe
  // counter is five bits, so the settle count must stay below 32
  always @(posedge mclk or negedge resetn) begin
    if (!resetn)
      settle_cnt <= 5'd0;
    else if (do_write && wr_reg == `PDAMW_MR6)
      settle_cnt <= settle_full[4:0];
    else if (settle_cnt != 5'd0)
      settle_cnt <= settle_cnt - 5'd1;
  end
  assign vref_settled = (settle_cnt == 5'd0);

  // termination: no dynamic switch while qualifying, follow odt instead
  assign nominal_en           = (mr[`PDAMW_MR1][10:8] != 3'b000);
  assign term_dynamic_allowed = ~pda_active;                                 // [R9]
  assign term_nominal_on      = nominal_en & term_raw;                       // [R10]
  // park only while nominal is off, so the two never overlap
  assign term_park_on         = (mr[`PDAMW_MR5][8:6] != 3'b000) & ~term_nominal_on;

  pdamw_term_delay u_term (
    .mclk       (mclk),
    .resetn     (resetn),
    .odt_level  (odt_s),
    .async_mode (ctrl[`PDAMW_CTRL_ASYNC]),
    .term_on    (term_raw)
  );

  // classic wishbone slave, one wait state, unmapped reads give zero
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl     <= 2'b00;
      mr_sel   <= 3'h0;
    end else begin
      wb_ack_o <= bus_req;
      // only byte lane 0 carries writable bits
      if (bus_req && wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          `PDAMW_ADR_CTRL:  ctrl   <= wb_dat_i[1:0];
          `PDAMW_ADR_MRSEL: mr_sel <= wb_dat_i[2:0];
          default: ;
        endcase
      end
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          `PDAMW_ADR_CTRL:   wb_dat_o <= {30'h0, ctrl};
          `PDAMW_ADR_STATUS: wb_dat_o <= {8'h00, disc_cnt, exec_cnt, 4'h0,
                                          vref_settled, last_dq0,
                                          state, pda_active};
          `PDAMW_ADR_MRSEL:  wb_dat_o <= {29'h0, mr_sel};
          `PDAMW_ADR_MRDATA: wb_dat_o <= {18'h0, mr[mr_sel]};
          `PDAMW_ADR_VREF:   wb_dat_o <= {11'h0, vref_range, vref_code,
                                          vref_level[13:0]};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // pdamw_top
`default_nettype wire
